/* hdl/clk_select_map.svh */
// Contract
// - six high-clock options chosen by a static option code.
// - slow clock comes from the internal slow RC, picked by the mode-select bit.
// - normal mode divides the high clock by a static factor 1 to 16.
// - slow mode instruction rate is always slow RC divided by four.
// - internal-RC options clamp the divider to 4 through 16.
// - with noise filter on, high-clock divider never goes below four.
// - noise filter acts only on the external oscillator path.
// - internal-only option frees both oscillator pins as general I/O.
// - internal-with-RTC option gives both pins to the 32768Hz crystal.
// - internal-with-RTC runs system on fast RC, RTC on the crystal.
// - external RC uses only the input pin; output pin stays general I/O.
// - external 32K crystal is the high clock and RTC ticks keep working.
// - green mode with RTC keeps crystal and fast RC, stops slow RC.
// - always-on watchdog keeps the slow RC running in that green case.
// - green entered from slow mode with stop bit set stops the fast RC.
// - fast RC is enabled only under an internal-RC option, and not in sleep or once stopped.
// - mode-select bit 0 means high clock, 1 means slow RC clock.
// - stop bit disables the selected high source; with RTC also the crystal.
// - operating mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
`ifndef CLK_SELECT_MAP_SVH
`define CLK_SELECT_MAP_SVH

// register indices and byte addresses (address is four times the index)
`define OSC_MODE_REG_IDX    8'hCA
`define OSC_MODE_REG_ADDR   12'h328
`define CLK_STATUS_REG_IDX  8'hCB
`define CLK_STATUS_REG_ADDR 12'h32C

// oscillator mode register fields
`define OSCMODE_STOP_BIT    1
`define OSCMODE_SEL_BIT     2
`define OSCMODE_OPMODE_LSB  3
`define OSCMODE_OPMODE_MSB  4
`define OSCMODE_RESET       8'h01

// divider figures
`define SLOW_DIV_FACTOR     5'h04
`define LIMITED_MIN_DIV     5'h04
`define MAX_DIV_FACTOR      5'h10
`define NOISE_FILTER_LEN    4

// bus answers
`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

`endif

/* hdl/clk_select_pkg.sv */
package clk_select_pkg;
  // high-clock option codes
  typedef enum logic [2:0] {
    OPT_INT_FAST_ONLY = 3'h0, OPT_INT_FAST_RTC = 3'h1, OPT_EXT_RC = 3'h2,
    OPT_EXT_32K = 3'h3, OPT_EXT_12M = 3'h4, OPT_EXT_4M = 3'h5
  } high_clk_e;
  // operating mode field
  typedef enum logic [1:0] {
    OPM_NORMAL = 2'h0, OPM_SLEEP = 2'h1, OPM_GREEN = 2'h2, OPM_RSVD = 2'h3
  } op_mode_e;
  // system clock source state
  typedef enum logic [1:0] {SRC_FAST = 2'b01, SRC_SLOW = 2'b10} src_e;

  typedef struct packed {
    high_clk_e   opt;
    logic        filt_on;
    logic        wdt_on;
    logic [4:0]  div_opt;
    logic [2:0]  fast_sync, slow_sync, in_sync, out_sync;
    logic        fast_lvl, slow_lvl, in_lvl, out_lvl, in_filt;
    logic [3:0]  filt_cnt;
    logic        stop_bit, sel_bit;
    op_mode_e    op_mode;
    src_e        src;
    logic [4:0]  div_cnt;
    logic        fcpu_pulse, rtc_tick;
    logic        fast_en, slow_en, ext_en, in_gpio, out_gpio;
    logic        in_o, in_oe, out_o, out_oe;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        aw_got, w_got;
    logic [11:0] aw_addr;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
  } state_s;
endpackage

/* hdl/dual_clock_source_select.sv */
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "clk_select_map.svh"
module dual_clock_source_select (
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    reset_in,
  // static options, caught while reset is held
  input  wire clk_select_pkg::high_clk_e opt_high_clk_in,
  input  wire logic                    opt_noise_filter_in,
  input  wire logic [4:0]              opt_fcpu_div_in,
  input  wire logic                    opt_wdt_always_on_in,
  // oscillator outputs and wake event
  input  wire logic                    internal_fast_rc_clk_in,
  input  wire logic                    internal_slow_rc_clk_in,
  input  wire logic                    wake_in,
  // oscillator pins and their general I/O side
  input  wire logic                    osc_input_pin_in,
  output logic                         osc_input_pin_out,
  output logic                         osc_input_pin_oe_out,
  input  wire logic                    osc_output_pin_in,
  output logic                         osc_output_pin_out,
  output logic                         osc_output_pin_oe_out,
  input  wire logic [1:0]              gpio_data_in,
  input  wire logic [1:0]              gpio_drive_in,
  output logic [1:0]                   gpio_read_out,
  output logic [1:0]                   gpio_free_out,
  // oscillator enables and derived rates
  output logic                         internal_fast_rc_en_out,
  output logic                         internal_slow_rc_en_out,
  output logic                         ext_osc_en_out,
  output logic                         instr_cycle_pulse_out,
  output logic                         rtc_tick_out,
  // axi4-lite slave
  input  wire logic [11:0]             s_axi_awaddr_in,
  input  wire logic                    s_axi_awvalid_in,
  output logic                         s_axi_awready_out,
  input  wire logic [31:0]             s_axi_wdata_in,
  input  wire logic [3:0]              s_axi_wstrb_in,
  input  wire logic                    s_axi_wvalid_in,
  output logic                         s_axi_wready_out,
  output logic [1:0]                   s_axi_bresp_out,
  output logic                         s_axi_bvalid_out,
  input  wire logic                    s_axi_bready_in,
  input  wire logic [11:0]             s_axi_araddr_in,
  input  wire logic                    s_axi_arvalid_in,
  output logic                         s_axi_arready_out,
  output logic [31:0]                  s_axi_rdata_out,
  output logic [1:0]                   s_axi_rresp_out,
  output logic                         s_axi_rvalid_out,
  input  wire logic                    s_axi_rready_in
);
  import clk_select_pkg::*;

  state_s s_reg;
  state_s s_next;

  // internal-RC options run the system from the fast RC
  function automatic logic is_internal(input high_clk_e o);
    return (o == OPT_INT_FAST_ONLY) || (o == OPT_INT_FAST_RTC);
  endfunction

  // crystal options own both pins
  function automatic logic is_crystal(input high_clk_e o);
    return (o == OPT_INT_FAST_RTC) || (o == OPT_EXT_32K) ||
           (o == OPT_EXT_12M) || (o == OPT_EXT_4M);
  endfunction

  // effective divider; 0 or above 16 falls back to the nearest legal value
  function automatic logic [4:0] eff_div(input logic [4:0] d, input high_clk_e o,
                                         input logic filt);
    logic [4:0] r;
    r = (d == 5'h00) ? 5'h01 : ((d > `MAX_DIV_FACTOR) ? `MAX_DIV_FACTOR : d);
    if ((is_internal(o) || filt) && (r < `LIMITED_MIN_DIV))
      r = `LIMITED_MIN_DIV;
    return r;
  endfunction

  logic       fast_rise;
  logic       slow_rise;
  logic       ext_rise;
  logic       hi_tick;
  logic       src_tick;
  logic [4:0] target;
  logic       want_slow;
  logic       aw_take;
  logic       w_take;
  logic       ext_opt;
  logic       green_rtc;

  // next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    ext_opt = !is_internal(s_reg.opt);

    // three-stage sampling; a level counts once stages two and three agree
    s_next.fast_sync = {s_reg.fast_sync[1:0], internal_fast_rc_clk_in};
    s_next.slow_sync = {s_reg.slow_sync[1:0], internal_slow_rc_clk_in};
    s_next.in_sync   = {s_reg.in_sync[1:0], osc_input_pin_in};
    s_next.out_sync  = {s_reg.out_sync[1:0], osc_output_pin_in};
    if (s_reg.fast_sync[1] == s_reg.fast_sync[2]) s_next.fast_lvl = s_reg.fast_sync[2];
    if (s_reg.slow_sync[1] == s_reg.slow_sync[2]) s_next.slow_lvl = s_reg.slow_sync[2];
    if (s_reg.in_sync[1] == s_reg.in_sync[2])     s_next.in_lvl = s_reg.in_sync[2];
    if (s_reg.out_sync[1] == s_reg.out_sync[2])   s_next.out_lvl = s_reg.out_sync[2];
    fast_rise = s_next.fast_lvl & ~s_reg.fast_lvl;
    slow_rise = s_next.slow_lvl & ~s_reg.slow_lvl;

    // low-pass on the external path only: a level must hold for a few samples
    if (s_reg.filt_on && ext_opt) begin
      if (s_reg.in_lvl == s_reg.in_filt) begin
        s_next.filt_cnt = 4'h0;
      end else if (s_reg.filt_cnt == 4'(`NOISE_FILTER_LEN - 1)) begin
        s_next.filt_cnt = 4'h0;
        s_next.in_filt = s_reg.in_lvl;
      end else begin
        s_next.filt_cnt = s_reg.filt_cnt + 4'h1;
      end
    end else begin
      s_next.filt_cnt = 4'h0;
      s_next.in_filt = s_reg.in_lvl;
    end
    ext_rise = s_next.in_filt & ~s_reg.in_filt;

    // high clock: fast RC for internal options, otherwise the input pin
    hi_tick = is_internal(s_reg.opt) ? fast_rise : ext_rise;
    // real-time tick from the crystal in the two options that keep it
    s_next.rtc_tick = ((s_reg.opt == OPT_INT_FAST_RTC) || (s_reg.opt == OPT_EXT_32K)) &&
                      ext_rise;

    // divider; the source only changes right after the count completes a full cycle
    want_slow = s_reg.sel_bit;
    src_tick = (s_reg.src == SRC_SLOW) ? slow_rise : hi_tick;
    target = (s_reg.src == SRC_SLOW) ? `SLOW_DIV_FACTOR :
             eff_div(s_reg.div_opt, s_reg.opt, s_reg.filt_on);
    s_next.fcpu_pulse = 1'b0;
    if (src_tick) begin
      if (s_reg.div_cnt >= target - 5'h01) begin
        s_next.div_cnt = 5'h00;
        // the cpu sleeps in green and sleep modes, so no cycles are issued
        s_next.fcpu_pulse = (s_reg.op_mode == OPM_NORMAL);
        s_next.src = want_slow ? SRC_SLOW : SRC_FAST;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 5'h01;
      end
    end

    // wake returns the cpu to normal; a write in the same cycle still lands
    if (wake_in) s_next.op_mode = OPM_NORMAL;

    // axi write: address and data may come in either order
    aw_take = s_axi_awvalid_in && s_reg.awready;
    w_take = s_axi_wvalid_in && s_reg.wready;
    if (aw_take) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr_in;
    end
    if (w_take) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata_in[7:0];
      s_next.w_lane0 = s_axi_wstrb_in[0];
    end
    if (s_reg.bvalid && s_axi_bready_in) s_next.bvalid = 1'b0;
    if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      if (s_next.aw_addr[11:2] == 10'(`OSC_MODE_REG_ADDR >> 2)) begin
        if (s_next.w_lane0) begin
          s_next.stop_bit = s_next.w_data[`OSCMODE_STOP_BIT];
          s_next.sel_bit = s_next.w_data[`OSCMODE_SEL_BIT];
          // the reserved code is ignored and the field keeps its value
          if (s_next.w_data[`OSCMODE_OPMODE_MSB:`OSCMODE_OPMODE_LSB] != OPM_RSVD)
            s_next.op_mode = op_mode_e'(s_next.w_data[`OSCMODE_OPMODE_MSB:
                                                      `OSCMODE_OPMODE_LSB]);
        end
      end else if (s_next.aw_addr[11:2] != `CLK_STATUS_REG_ADDR >> 2) begin
        s_next.bresp = `RESP_DECERR;
      end
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // axi read: one beat, unmapped reads return zero with a decode error
    if (s_reg.rvalid && s_axi_rready_in) s_next.rvalid = 1'b0;
    if (s_axi_arvalid_in && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (s_axi_araddr_in[11:2] == `OSC_MODE_REG_ADDR >> 2) begin
        s_next.rdata[7:0] = {3'h0, s_reg.op_mode, s_reg.sel_bit, s_reg.stop_bit, 1'b1};
      end else if (s_axi_araddr_in[11:2] == `CLK_STATUS_REG_ADDR >> 2) begin
        s_next.rdata[9:0] = {s_reg.opt[2:0], s_reg.src == SRC_SLOW, s_reg.fast_en,
                             s_reg.slow_en, s_reg.ext_en, s_reg.in_gpio,
                             s_reg.out_gpio, s_reg.filt_on};
      end else begin
        s_next.rresp = `RESP_DECERR;
      end
    end
    s_next.arready = !s_next.rvalid;

    // oscillator enables; the stop bit only bites once the slow clock is in use
    green_rtc = (s_next.op_mode == OPM_GREEN) && (s_reg.opt == OPT_INT_FAST_RTC);
    s_next.fast_en = is_internal(s_reg.opt) && (s_next.op_mode != OPM_SLEEP) &&
                     !(s_next.stop_bit && s_next.sel_bit && s_next.src == SRC_SLOW);
    s_next.ext_en = is_crystal(s_reg.opt) || ext_opt;
    s_next.ext_en = s_next.ext_en && (s_next.op_mode != OPM_SLEEP) &&
                    !(s_next.stop_bit && s_next.sel_bit && s_next.src == SRC_SLOW) &&
                    (s_reg.opt != OPT_INT_FAST_ONLY);
    s_next.slow_en = s_reg.wdt_on ||
                     ((s_next.op_mode != OPM_SLEEP) && !green_rtc);

    // pin ownership by option
    s_next.in_gpio = (s_reg.opt == OPT_INT_FAST_ONLY);
    s_next.out_gpio = (s_reg.opt == OPT_INT_FAST_ONLY) ||
                      (s_reg.opt == OPT_EXT_RC);
    s_next.in_o = gpio_data_in[0];
    s_next.in_oe = s_next.in_gpio && gpio_drive_in[0];
    // crystal amplifier: drive the inverse of the input while it runs
    s_next.out_o = s_next.out_gpio ? gpio_data_in[1] : ~s_reg.in_lvl;
    s_next.out_oe = s_next.out_gpio ? gpio_drive_in[1] :
                    (is_crystal(s_reg.opt) && s_next.ext_en);
  end

  // state register; options are caught only while reset is held
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_reg <= '0;
      s_reg.opt <= opt_high_clk_in;
      s_reg.filt_on <= opt_noise_filter_in;
      s_reg.div_opt <= opt_fcpu_div_in;
      s_reg.wdt_on <= opt_wdt_always_on_in;
      s_reg.op_mode <= OPM_NORMAL;
      s_reg.src <= SRC_FAST;
      s_reg.slow_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign osc_input_pin_out       = s_reg.in_o;
  assign osc_input_pin_oe_out    = s_reg.in_oe;
  assign osc_output_pin_out      = s_reg.out_o;
  assign osc_output_pin_oe_out   = s_reg.out_oe;
  assign gpio_read_out           = {s_reg.out_lvl, s_reg.in_lvl};
  assign gpio_free_out           = {s_reg.out_gpio, s_reg.in_gpio};
  assign internal_fast_rc_en_out = s_reg.fast_en;
  assign internal_slow_rc_en_out = s_reg.slow_en;
  assign ext_osc_en_out          = s_reg.ext_en;
  assign instr_cycle_pulse_out   = s_reg.fcpu_pulse;
  assign rtc_tick_out            = s_reg.rtc_tick;
  assign s_axi_awready_out       = s_reg.awready;
  assign s_axi_wready_out        = s_reg.wready;
  assign s_axi_bresp_out         = s_reg.bresp;
  assign s_axi_bvalid_out        = s_reg.bvalid;
  assign s_axi_arready_out       = s_reg.arready;
  assign s_axi_rdata_out         = s_reg.rdata;
  assign s_axi_rresp_out         = s_reg.rresp;
  assign s_axi_rvalid_out        = s_reg.rvalid;

  // checks on the block's own behaviour
  a_int_pins_free: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.opt == OPT_INT_FAST_ONLY |=> gpio_free_out == 2'b11)
    else $error("internal-only option must free both pins");
  a_rtc_pins_owned: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.opt == OPT_INT_FAST_RTC |=> gpio_free_out == 2'b00)
    else $error("rtc option must own both pins");
  a_ext_rc_pins: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.opt == OPT_EXT_RC |=> gpio_free_out == 2'b10)
    else $error("external rc must leave only the output pin free");
  a_ext_fast_off: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !is_internal(s_reg.opt) |=> !internal_fast_rc_en_out)
    else $error("fast rc running under an external option");
  a_green_rtc_slow: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_next.op_mode == OPM_GREEN && s_reg.opt == OPT_INT_FAST_RTC
      |=> internal_slow_rc_en_out == s_reg.wdt_on)
    else $error("slow rc state wrong in rtc green mode");
  a_slow_div_four: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.fcpu_pulse && s_reg.src == SRC_SLOW && $past(s_reg.src) == SRC_SLOW
      |-> $past(s_reg.div_cnt) == 5'h03)
    else $error("slow mode cycle is not four slow edges");
  a_div_floor: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.fcpu_pulse && s_reg.src == SRC_FAST && (is_internal(s_reg.opt) || s_reg.filt_on)
      && $past(s_reg.src) == SRC_FAST |-> $past(s_reg.div_cnt) >= 5'h03)
    else $error("limited divider issued a cycle too soon");
  a_no_cycle_asleep: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(s_reg.fcpu_pulse) |-> $past(s_reg.op_mode) == OPM_NORMAL && s_reg.div_cnt == 5'h00)
    else $error("instruction cycle out of place");
  a_bvalid_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped before accepted");

  // oscillator enables follow the option, the mode field and the stop bit; no cycles while idle
  a_fast_on_int: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    is_internal(s_reg.opt) && s_next.op_mode == OPM_NORMAL && !s_next.stop_bit
      |=> internal_fast_rc_en_out)
    else $error("fast rc stopped under an internal option");
  a_green_rtc_run: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_next.op_mode == OPM_GREEN && s_reg.opt == OPT_INT_FAST_RTC && !s_next.stop_bit
      |=> internal_fast_rc_en_out && ext_osc_en_out)
    else $error("rtc green mode lost the fast rc or the crystal");
  a_slow_wdt_kept: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.wdt_on |=> internal_slow_rc_en_out)
    else $error("slow rc stopped while the watchdog must run");
  a_stop_rtc_both: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_next.stop_bit && s_next.sel_bit && s_next.src == SRC_SLOW &&
      s_reg.opt == OPT_INT_FAST_RTC |=> !internal_fast_rc_en_out && !ext_osc_en_out)
    else $error("stop bit left a high source running");
  a_green_fast_stop: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_next.op_mode == OPM_GREEN && s_next.stop_bit && s_next.sel_bit &&
      s_next.src == SRC_SLOW |=> !internal_fast_rc_en_out)
    else $error("fast rc kept in green mode entered from slow with stop set");
  a_sleep_all_off: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_next.op_mode == OPM_SLEEP |=> !internal_fast_rc_en_out && !ext_osc_en_out &&
      internal_slow_rc_en_out == s_reg.wdt_on)
    else $error("an oscillator kept running in sleep mode");
  a_no_pulse_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.op_mode != OPM_NORMAL |=> !instr_cycle_pulse_out)
    else $error("instruction cycle issued while the cpu is idle");
  // pins and the external clock path
  a_crystal_amp: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    is_crystal(s_reg.opt) && s_next.ext_en |=> osc_output_pin_oe_out)
    else $error("crystal option does not drive the output pin");
  a_filter_bypass: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !s_reg.filt_on || is_internal(s_reg.opt) |=> s_reg.in_filt == $past(s_reg.in_lvl))
    else $error("noise filter acting outside the external path");
  a_rtc_tick_only: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rtc_tick_out |-> s_reg.opt == OPT_INT_FAST_RTC || s_reg.opt == OPT_EXT_32K)
    else $error("rtc tick under an option without a crystal rtc");
  // divider and source switch
  a_div_ceiling: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_reg.div_cnt < `MAX_DIV_FACTOR)
    else $error("divider count beyond the largest factor");
  a_src_at_cycle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $changed(s_reg.src) |-> s_reg.div_cnt == 5'h00)
    else $error("clock source switched inside an instruction cycle");
  // bus handshakes
  a_rvalid_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped or changed before accepted");
  a_ready_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write channel ready while a response is pending");
endmodule // dual_clock_source_select

/* testbench/osc_crystal_model.sv */
`timescale 1ns/100ps
// crystal or rc network hanging on the oscillator input pin
module osc_crystal_model #(
  parameter int HALF_NS = 64  // half period; raise it for a slow oscillator
) (
  // oscillator enable from the block
  input  wire logic enable_in,
  // waveform offered to the input pin
  output logic      drive_out,
  output logic      level_out
);
  // swings only while enabled; the start offset keeps edges away from the clock edges
  initial begin
    level_out = 1'b0;
    forever begin
      drive_out = (enable_in === 1'b1);
      if (drive_out) begin
        #(HALF_NS) level_out = ~level_out;
      end else begin
        @(enable_in);
        #3;
      end
    end
  end
endmodule // osc_crystal_model

/* testbench/dual_clock_source_select_bench.sv */
`timescale 1ns/100ps
`include "clk_select_map.svh"
module dual_clock_source_select_bench;
  import clk_select_pkg::*;
  typedef struct {high_clk_e opt; logic filt; logic [4:0] div; logic [2:0] en;
                  logic [1:0] free; int gap;} row_t;
  // options, oscillators and pins
  logic        clk = 1'b0, rst = 1'b1, fast_rc = 1'b0, slow_rc = 1'b0, wake = 1'b0;
  logic        filt = 1'b0, wdt = 1'b0, flt = 1'b0;
  high_clk_e   opt = OPT_INT_FAST_ONLY;
  logic [4:0]  div = 5'h01;
  logic [1:0]  gdata = 2'h1, gdrive = 2'h3, gread, gfree, r;
  logic        in_o, in_oe, out_o, out_oe, fast_en, slow_en, ext_en, pulse, tick, x_drv, x_lvl;
  wire logic   in_pin, out_pin;
  // register bus
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          error_cnt = 0, comparisons = 0, pcnt = 0, tcnt = 0, n, t0;
  // fast rc 8 cycles, slow rc 32 cycles, edges kept off the rising clock
  row_t rows[6] = '{'{OPT_INT_FAST_ONLY, 1'b0, 5'h01, 3'b110, 2'b11, 32},
                    '{OPT_INT_FAST_RTC, 1'b0, 5'h10, 3'b111, 2'b00, 128},
                    '{OPT_EXT_RC, 1'b1, 5'h02, 3'b011, 2'b10, 64},
                    '{OPT_EXT_32K, 1'b0, 5'h01, 3'b011, 2'b00, 16},
                    '{OPT_EXT_12M, 1'b0, 5'h03, 3'b011, 2'b00, 48},
                    '{OPT_EXT_4M, 1'b1, 5'h08, 3'b011, 2'b00, 128}};

  always #4 clk = ~clk;
  always #32 fast_rc = ~fast_rc;
  always #128 slow_rc = ~slow_rc;
  // a released pin shows a level that changes every cycle, never a stale one
  always @(posedge clk) begin
    flt <= ~flt;
    pcnt <= pcnt + int'(pulse);
    tcnt <= tcnt + int'(tick);
  end
  assign in_pin = in_oe ? in_o : (x_drv ? x_lvl : flt);
  assign out_pin = out_oe ? out_o : flt;

  dual_clock_source_select dual_clock_source_select_inst (
    .ref_clk_in(clk), .reset_in(rst), .opt_high_clk_in(opt), .opt_noise_filter_in(filt),
    .opt_fcpu_div_in(div), .opt_wdt_always_on_in(wdt), .internal_fast_rc_clk_in(fast_rc),
    .internal_slow_rc_clk_in(slow_rc), .wake_in(wake), .osc_input_pin_in(in_pin),
    .osc_input_pin_out(in_o), .osc_input_pin_oe_out(in_oe), .osc_output_pin_in(out_pin),
    .osc_output_pin_out(out_o), .osc_output_pin_oe_out(out_oe), .gpio_data_in(gdata),
    .gpio_drive_in(gdrive), .gpio_read_out(gread), .gpio_free_out(gfree),
    .internal_fast_rc_en_out(fast_en), .internal_slow_rc_en_out(slow_en),
    .ext_osc_en_out(ext_en), .instr_cycle_pulse_out(pulse), .rtc_tick_out(tick),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  osc_crystal_model osc_crystal_model_inst (.enable_in(ext_en), .drive_out(x_drv),
                                            .level_out(x_lvl));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // options are only caught while reset is held
  task automatic boot(input high_clk_e o, input logic f, input logic [4:0] v, input logic w);
    opt <= o;
    filt <= f;
    div <= v;
    wdt <= w;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({fast_en, slow_en, ext_en, pulse, awready, arready}, 6'b010000);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] v);
    awaddr <= `OSC_MODE_REG_ADDR;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, `RESP_OKAY);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // cycles between two instruction pulses, after the next one shows up
  task automatic gap();
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (pulse !== 1'b1 && k < 3000);
    n = 0;
    do begin @(posedge clk); n++; end while (pulse !== 1'b1 && n < 3000);
  endtask

  initial begin
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      boot(rows[i].opt, rows[i].filt, rows[i].div, 1'b0);
      t0 = tcnt;
      gap();
      gap();
      chk(n, rows[i].gap);
      chk({fast_en, slow_en, ext_en}, rows[i].en);
      chk(gfree, rows[i].free);
      chk({out_oe, in_oe} & gfree, gfree);
      if (gfree == 2'b11) chk(gread, gdata);
      if (rows[i].free == 2'b00) chk(out_oe, 1'b1);
      chk(tcnt != t0, rows[i].opt == OPT_INT_FAST_RTC || rows[i].opt == OPT_EXT_32K);
      rd(`CLK_STATUS_REG_ADDR);
      chk({d[9:7], d[0]}, {rows[i].opt, rows[i].filt});
      $display("option row %0d done", i);
    end
    boot(OPT_INT_FAST_RTC, 1'b0, 5'h04, 1'b0);
    rd(`OSC_MODE_REG_ADDR);
    chk(d, 32'h01);
    rd(12'h000);
    chk({r, d[29:0]}, {`RESP_DECERR, 30'h0});
    wr(8'h18);
    rd(`OSC_MODE_REG_ADDR);
    chk(d, 32'h01);
    wr(8'h10);
    t0 = pcnt;
    chk({fast_en, slow_en, ext_en}, 3'b101);
    repeat (200) @(posedge clk);
    chk(pcnt - t0, 0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    gap();
    gap();
    chk(n, 32);
    $display("register and green test done");
    wr(8'h04);
    gap();
    gap();
    chk(n, 128);
    wr(8'h06);
    chk({fast_en, slow_en, ext_en}, 3'b010);
    gap();
    gap();
    chk(n, 128);
    wr(8'h16);
    chk(fast_en, 1'b0);
    $display("slow and stop test done");
    boot(OPT_INT_FAST_RTC, 1'b0, 5'h04, 1'b1);
    wr(8'h10);
    chk({fast_en, slow_en, ext_en}, 3'b111);
    wr(8'h08);
    chk({fast_en, slow_en, ext_en}, 3'b010);
    $display("watchdog and sleep test done");
    results();
  end

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // dual_clock_source_select_bench
